/* hw/bst_pkg.sv */
// bst_pkg: constants and types shared by the tap controller and the top
// assumes the test link is clocked by tck and the rest of the chip by core_clk
// ===========================================================================
// Behaviour
// - instruction codes: 0 bypass,1 preload/sample,2 id,3 user,4 clamp,5 hiz,7 extest,8,9,10
// - boundary path 24 bits, id and user 32, read 7 in 8 out, write 7+8
// - entering test-logic-reset loads the identification instruction
// - five successive high tms samples always reach test-logic-reset
// - tms sampled on rising tck picks the next tap state
// - tdi sampled on rising tck feeds the chain chosen by state and instruction
// - tdo updates on falling tck from the selected chain
// - tdo driver is released outside the shifting states
// - a stopped tck keeps tap state and all register contents
// - bypass passes tdi to tdo through one cell, function untouched
// - cells 2 to 23 control, drive or capture; odd cells enable the pad cell below, 0 and 1 are spare
// - fixed pad order from clock out at 22 down to signal input at 2
// - interface switch bit at update: 1 turns host off, opens register access
// - read: capture loads data at current address, update sets new address
// - write: capture takes address and data from the chain and writes
// - user code is three product bytes then a version byte from config
`default_nettype none

package bst_pkg;
   // ========================================================================
   // instruction codes
   localparam int         IR_W      = 4;
   localparam logic [3:0] IR_BYPASS = 4'h0;
   localparam logic [3:0] IR_SAMPLE = 4'h1;
   localparam logic [3:0] IR_IDCODE = 4'h2;
   localparam logic [3:0] IR_USER   = 4'h3;
   localparam logic [3:0] IR_CLAMP  = 4'h4;
   localparam logic [3:0] IR_HIGHZ  = 4'h5;
   localparam logic [3:0] IR_EXTEST = 4'h7;
   localparam logic [3:0] IR_IFSW   = 4'h8;
   localparam logic [3:0] IR_REGRD  = 4'h9;
   localparam logic [3:0] IR_REGWR  = 4'hA;
   localparam logic [3:0] IR_CAPVAL = 4'h1; // fixed capture-ir pattern

   // ========================================================================
   // chain lengths and field layout
   localparam int BS_LEN   = 24;
   localparam int ID_LEN   = 32;
   localparam int ADDR_W   = 7;
   localparam int DATA_W   = 8;
   localparam int RD_LEN   = 8;
   localparam int WR_LEN   = 15;
   localparam int WR_DPOS  = 7;  // write data sits above the address
   localparam int NPADS    = 11;
   localparam int PAD_POS0 = 2;  // position of the lowest pad cell

   // ========================================================================
   // pad index of each bidirectional pin, pad cell at 2+2*index
   localparam int SIGNAL_INPUT_PAD           = 0;
   localparam int INTERRUPT_PAD              = 1;
   localparam int HOST_PORT3_PAD             = 2;
   localparam int HOST_PORT2_PAD             = 3;
   localparam int HOST_PORT1_PAD             = 4;
   localparam int HOST_PORT0_PAD             = 5;
   localparam int HOST_SELECT1_PAD           = 6;
   localparam int HOST_SELECT0_PAD           = 7;
   localparam int SECONDARY_SERIAL_DATA_PAD  = 8;
   localparam int SECONDARY_SERIAL_CLOCK_PAD = 9;
   localparam int CLOCK_OUT_PAD              = 10;

   // ========================================================================
   // tap controller states
   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE,
      TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR,
      TAP_UPD_DR,
      TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR,
      TAP_UPD_IR
   } bst_tap_t;
endpackage

`default_nettype wire

/* hw/bst_tap_ctrl.sv */
// bst_tap_ctrl: sixteen state test access port controller on tck
// assumes tms changes on falling tck and tapRst is already on tck
`default_nettype none

module bst_tap_ctrl (
   input  wire logic   tck,
   input  wire logic   tapRst,
   input  wire logic   tms,
   bst_tap_if.ctrl     ifc
);
   typedef struct packed {
      bst_pkg::bst_tap_t st;
   } bst_fsm_t;

   bst_fsm_t s_q;
   bst_fsm_t s_d;

   // ========================================================================
   // next state from present state and sampled tms
   always_comb begin
      s_d = s_q;
      case (s_q.st)
         bst_pkg::TAP_RESET:  s_d.st = tms ? bst_pkg::TAP_RESET  : bst_pkg::TAP_IDLE;
         bst_pkg::TAP_IDLE:   s_d.st = tms ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
         bst_pkg::TAP_SEL_DR: s_d.st = tms ? bst_pkg::TAP_SEL_IR : bst_pkg::TAP_CAP_DR;
         bst_pkg::TAP_CAP_DR: s_d.st = tms ? bst_pkg::TAP_EX1_DR : bst_pkg::TAP_SH_DR;
         bst_pkg::TAP_SH_DR:  s_d.st = tms ? bst_pkg::TAP_EX1_DR : bst_pkg::TAP_SH_DR;
         bst_pkg::TAP_EX1_DR: s_d.st = tms ? bst_pkg::TAP_UPD_DR : bst_pkg::TAP_PAU_DR;
         bst_pkg::TAP_PAU_DR: s_d.st = tms ? bst_pkg::TAP_EX2_DR : bst_pkg::TAP_PAU_DR;
         bst_pkg::TAP_EX2_DR: s_d.st = tms ? bst_pkg::TAP_UPD_DR : bst_pkg::TAP_SH_DR;
         bst_pkg::TAP_UPD_DR: s_d.st = tms ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
         bst_pkg::TAP_SEL_IR: s_d.st = tms ? bst_pkg::TAP_RESET  : bst_pkg::TAP_CAP_IR;
         bst_pkg::TAP_CAP_IR: s_d.st = tms ? bst_pkg::TAP_EX1_IR : bst_pkg::TAP_SH_IR;
         bst_pkg::TAP_SH_IR:  s_d.st = tms ? bst_pkg::TAP_EX1_IR : bst_pkg::TAP_SH_IR;
         bst_pkg::TAP_EX1_IR: s_d.st = tms ? bst_pkg::TAP_UPD_IR : bst_pkg::TAP_PAU_IR;
         bst_pkg::TAP_PAU_IR: s_d.st = tms ? bst_pkg::TAP_EX2_IR : bst_pkg::TAP_PAU_IR;
         bst_pkg::TAP_EX2_IR: s_d.st = tms ? bst_pkg::TAP_UPD_IR : bst_pkg::TAP_SH_IR;
         bst_pkg::TAP_UPD_IR: s_d.st = tms ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
         default:             s_d.st = bst_pkg::TAP_RESET;
      endcase
      if (tapRst) begin
         s_d.st = bst_pkg::TAP_RESET;
      end
   end

   // state only moves on a tck edge, so a parked tck freezes it
   always_ff @(posedge tck) begin
      s_q <= s_d;
   end

   // decoded flags for the chains
   assign ifc.tlr   = (s_q.st == bst_pkg::TAP_RESET);
   assign ifc.capIr = (s_q.st == bst_pkg::TAP_CAP_IR);
   assign ifc.shIr  = (s_q.st == bst_pkg::TAP_SH_IR);
   assign ifc.updIr = (s_q.st == bst_pkg::TAP_UPD_IR);
   assign ifc.capDr = (s_q.st == bst_pkg::TAP_CAP_DR);
   assign ifc.shDr  = (s_q.st == bst_pkg::TAP_SH_DR);
   assign ifc.updDr = (s_q.st == bst_pkg::TAP_UPD_DR);

   // ========================================================================
   // checks
   five_tms_a: assert property (@(posedge tck) disable iff (tapRst)
      tms [*5] |=> ifc.tlr)
      else $error("five high tms did not reach reset");
   idle_step_a: assert property (@(posedge tck) disable iff (tapRst)
      (s_q.st == bst_pkg::TAP_IDLE) && tms |=> (s_q.st == bst_pkg::TAP_SEL_DR))
      else $error("idle with tms high did not select dr");
endmodule

`default_nettype wire

/* hw/bst_tap_if.sv */
// bst_tap_if: decoded tap state flags from the controller to the chains
// assumes both ends run on the same tck
`default_nettype none

interface bst_tap_if;
   logic tlr;
   logic capIr;
   logic shIr;
   logic updIr;
   logic capDr;
   logic shDr;
   logic updDr;
   modport ctrl (output tlr, capIr, shIr, updIr, capDr, shDr, updDr);
   modport user (input tlr, capIr, shIr, updIr, capDr, shDr, updDr);
endinterface

`default_nettype wire

/* hw/bst_top.sv */
// bst_top: boundary scan chains, tdo driver, pad muxing and register access
// assumes tck is the tester clock, core_clk the chip clock, rst on core_clk
`default_nettype none

module bst_top #(
   parameter logic [3:0]  ID_VERSION = 4'h6,      // arbitrary value
   parameter logic [15:0] ID_PART    = 16'h1234,  // arbitrary value
   parameter logic [10:0] ID_MAKER   = 11'h055    // arbitrary value
) (
   input  wire logic               core_clk,
   input  wire logic               rst,
   input  wire logic               tck,
   input  wire logic               tms,
   input  wire logic               tdi,
   output logic                    tdo,
   output logic                    tdoOe,
   input  wire logic [31:0]        cfgBytes,
   input  wire logic [10:0]        funcOut,
   input  wire logic [10:0]        funcOe,
   input  wire logic [10:0]        padIn,
   output logic      [10:0]        padOut,
   output logic      [10:0]        padOe,
   output logic                    hostIfOff,
   output logic      [6:0]         regRdAddr,
   input  wire logic [7:0]         regRdData,
   output logic      [6:0]         regWrAddr,
   output logic      [7:0]         regWrData,
   output logic                    regWrEn
);
   localparam logic [31:0] IDCODE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

   // ========================================================================
   // state types, one per clock edge
   typedef struct packed {
      logic [1:0]  rstS;
      logic [3:0]  irSh;
      logic [3:0]  ir;
      logic [31:0] dr;
      logic [23:0] bsUpd;
      logic        ifOff;
      logic [6:0]  curAddr;
      logic [6:0]  wrAddr;
      logic [7:0]  wrData;
      logic [7:0]  rdData;
      logic        rdTgl;
      logic        wrTgl;
      logic [2:0]  ackS;
      logic [10:0] padS1;
      logic [10:0] padS2;
      logic [31:0] cfgS1;
      logic [31:0] cfgS2;
      logic        drive;
      logic        hiz;
   } bst_tck_t;

   typedef struct packed {
      logic tdo;
      logic oe;
   } bst_neg_t;

   typedef struct packed {
      logic [2:0]  rdS;
      logic [2:0]  wrS;
      logic [1:0]  ifS;
      logic [1:0]  drvS;
      logic [1:0]  hizS;
      logic [23:0] bsS1;
      logic [23:0] bsS2;
      logic [6:0]  rdAddr;
      logic [6:0]  wrAddr;
      logic [7:0]  wrData;
      logic        wrEn;
      logic        rdPend;
      logic [7:0]  rdHold;
      logic        ackTgl;
      logic [10:0] padOut;
      logic [10:0] padOe;
      logic        ifOff;
   } bst_core_t;

   bst_tck_t  t_q;
   bst_tck_t  t_d;
   bst_neg_t  n_q;
   bst_neg_t  n_d;
   bst_core_t c_q;
   bst_core_t c_d;

   logic        tapRst;
   logic [23:0] capVec;
   logic [10:0] cellOut;
   logic [10:0] cellOe;
   logic [4:0]  lenM1;
   logic [31:0] userCode;

   bst_tap_if tap ();

   bst_tap_ctrl u_tap (
      .tck    (tck),
      .tapRst (tapRst),
      .tms    (tms),
      .ifc    (tap)
   );

   assign tapRst = t_q.rstS[1];

   // product bytes first, version byte last
   assign userCode = {t_q.cfgS2[7:0], t_q.cfgS2[15:8], t_q.cfgS2[23:16], t_q.cfgS2[31:24]};

   // ========================================================================
   // boundary cell map: pad cells capture their pin, odd cells enable the
   // pad cell just below, spare cells 0 and 1 recapture their own value
   for (genvar p = 0; p < bst_pkg::BS_LEN; p++) begin : g_cap
      if (p >= bst_pkg::PAD_POS0 && p % 2 == 0) begin : g_pad
         assign capVec[p] = t_q.padS2[(p - bst_pkg::PAD_POS0) / 2];
      end else begin : g_own
         assign capVec[p] = t_q.bsUpd[p];
      end
   end
   for (genvar i = 0; i < bst_pkg::NPADS; i++) begin : g_pad_map
      assign cellOut[i] = c_q.bsS2[bst_pkg::PAD_POS0 + 2 * i];
      assign cellOe[i]  = c_q.bsS2[bst_pkg::PAD_POS0 + 2 * i + 1];
   end

   // chain length for the active instruction, less one
   always_comb begin
      case (t_q.ir)
         bst_pkg::IR_SAMPLE, bst_pkg::IR_EXTEST: lenM1 = 5'(bst_pkg::BS_LEN - 1);
         bst_pkg::IR_IDCODE, bst_pkg::IR_USER:   lenM1 = 5'(bst_pkg::ID_LEN - 1);
         bst_pkg::IR_REGRD:                      lenM1 = 5'(bst_pkg::RD_LEN - 1);
         bst_pkg::IR_REGWR:                      lenM1 = 5'(bst_pkg::WR_LEN - 1);
         default:                                lenM1 = 5'h0;
      endcase
   end

   // ========================================================================
   // tck domain: instruction and data chains; tms and tdi need no
   // synchroniser since the tester moves them on falling tck
   always_comb begin
      t_d       = t_q;
      t_d.rstS  = {t_q.rstS[0], rst};
      t_d.ackS  = {t_q.ackS[1:0], c_q.ackTgl};
      t_d.padS1 = padIn;
      t_d.padS2 = t_q.padS1;
      t_d.cfgS1 = cfgBytes;
      t_d.cfgS2 = t_q.cfgS1;
      t_d.drive = (t_q.ir == bst_pkg::IR_EXTEST) || (t_q.ir == bst_pkg::IR_CLAMP);
      t_d.hiz   = (t_q.ir == bst_pkg::IR_HIGHZ);
      // read data has settled once the acknowledge toggle arrives
      if (t_q.ackS[2] != t_q.ackS[1]) begin
         t_d.rdData = c_q.rdHold;
      end
      // instruction chain
      if (tap.capIr) begin
         t_d.irSh = bst_pkg::IR_CAPVAL;
      end else if (tap.shIr) begin
         t_d.irSh = {tdi, t_q.irSh[3:1]};
      end
      if (tap.updIr) begin
         t_d.ir = t_q.irSh;
      end
      // data chain
      if (tap.capDr) begin
         case (t_q.ir)
            bst_pkg::IR_SAMPLE, bst_pkg::IR_EXTEST: t_d.dr = {8'h00, capVec};
            bst_pkg::IR_IDCODE: t_d.dr = IDCODE;
            bst_pkg::IR_USER:   t_d.dr = userCode;
            bst_pkg::IR_IFSW:   t_d.dr = {31'h0000_0000, t_q.ifOff};
            bst_pkg::IR_REGRD:  t_d.dr = {24'h00_0000, t_q.ifOff ? t_q.rdData : 8'h00};
            bst_pkg::IR_REGWR: begin
               if (t_q.ifOff) begin
                  t_d.wrAddr = t_q.dr[bst_pkg::ADDR_W-1:0];
                  t_d.wrData = t_q.dr[bst_pkg::WR_DPOS +: bst_pkg::DATA_W];
                  t_d.wrTgl  = ~t_q.wrTgl;
               end
            end
            default: t_d.dr = 32'h0000_0000;
         endcase
      end else if (tap.shDr) begin
         t_d.dr        = {1'b0, t_q.dr[31:1]};
         t_d.dr[lenM1] = tdi;
      end
      if (tap.updDr) begin
         case (t_q.ir)
            bst_pkg::IR_SAMPLE, bst_pkg::IR_EXTEST: t_d.bsUpd = t_q.dr[23:0];
            bst_pkg::IR_IFSW: t_d.ifOff = t_q.dr[0];
            bst_pkg::IR_REGRD: begin
               if (t_q.ifOff) begin
                  t_d.curAddr = t_q.dr[bst_pkg::ADDR_W-1:0];
                  t_d.rdTgl   = ~t_q.rdTgl;
               end
            end
            default: t_d.ifOff = t_q.ifOff;
         endcase
      end
      // chip reset clears the handshake toggles; a tap reset alone must not,
      // or the core side would see a toggle edge and replay a transfer
      if (tapRst) begin
         t_d.rdTgl = 1'b0;
         t_d.wrTgl = 1'b0;
      end
      // test-logic-reset restores the identification instruction
      if (tap.tlr) begin
         t_d.ir    = bst_pkg::IR_IDCODE;
         t_d.ifOff = 1'b0;
         t_d.drive = 1'b0;
         t_d.hiz   = 1'b0;
      end
   end

   // nothing moves without a tck edge, so a parked tck loses nothing
   always_ff @(posedge tck) begin
      t_q <= t_d;
   end

   // ========================================================================
   // tdo is launched on falling tck, released outside shift states
   always_comb begin
      n_d     = n_q;
      n_d.tdo = tap.shIr ? t_q.irSh[0] : t_q.dr[0];
      n_d.oe  = tap.shIr || tap.shDr;
   end

   always_ff @(negedge tck) begin
      n_q <= n_d;
   end

   // ========================================================================
   // core domain: toggles and quasi-static test levels crossing from tck
   always_comb begin
      c_d      = c_q;
      c_d.rdS  = {c_q.rdS[1:0], t_q.rdTgl};
      c_d.wrS  = {c_q.wrS[1:0], t_q.wrTgl};
      c_d.ifS  = {c_q.ifS[0], t_q.ifOff};
      c_d.drvS = {c_q.drvS[0], t_q.drive};
      c_d.hizS = {c_q.hizS[0], t_q.hiz};
      c_d.bsS1 = t_q.bsUpd;
      c_d.bsS2 = c_q.bsS1;
      c_d.ifOff = c_q.ifS[1];
      // write address and data held steady in tck since the toggle moved
      c_d.wrEn = c_q.wrS[2] ^ c_q.wrS[1];
      if (c_q.wrS[2] ^ c_q.wrS[1]) begin
         c_d.wrAddr = t_q.wrAddr;
         c_d.wrData = t_q.wrData;
      end
      // read: present address, sample data one cycle later, acknowledge
      if (c_q.rdS[2] ^ c_q.rdS[1]) begin
         c_d.rdAddr = t_q.curAddr;
         c_d.rdPend = 1'b1;
      end else if (c_q.rdPend) begin
         c_d.rdHold = regRdData;
         c_d.ackTgl = ~c_q.ackTgl;
         c_d.rdPend = 1'b0;
      end
      // pad mux: bypass and modes other than highz, extest and clamp leave function untouched
      if (c_q.hizS[1]) begin
         c_d.padOut = funcOut;
         c_d.padOe  = 11'h000;
      end else if (c_q.drvS[1]) begin
         c_d.padOut = cellOut;
         c_d.padOe  = cellOe;
      end else begin
         c_d.padOut = funcOut;
         c_d.padOe  = funcOe;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         c_q <= '0;
      end else begin
         c_q <= c_d;
      end
   end

   // outputs straight from flops
   assign tdo       = n_q.tdo;
   assign tdoOe     = n_q.oe;
   assign padOut    = c_q.padOut;
   assign padOe     = c_q.padOe;
   assign hostIfOff = c_q.ifOff;
   assign regRdAddr = c_q.rdAddr;
   assign regWrAddr = c_q.wrAddr;
   assign regWrData = c_q.wrData;
   assign regWrEn   = c_q.wrEn;

   // ========================================================================
   // checks
   tlr_ir_a: assert property (@(posedge tck) disable iff (tapRst)
      tap.tlr |=> (t_q.ir == bst_pkg::IR_IDCODE))
      else $error("reset state did not load identification");
   ir_shift_a: assert property (@(posedge tck) disable iff (tapRst)
      tap.shIr |=> (t_q.irSh[3] == $past(tdi)))
      else $error("tdi not shifted into instruction chain");
   ir_update_a: assert property (@(posedge tck) disable iff (tapRst)
      tap.updIr |=> (t_q.ir == $past(t_q.irSh)))
      else $error("instruction not updated");
   id_cap_a: assert property (@(posedge tck) disable iff (tapRst)
      tap.capDr && (t_q.ir == bst_pkg::IR_IDCODE) |=> (t_q.dr == IDCODE))
      else $error("identification not captured");
   byp_path_a: assert property (@(posedge tck) disable iff (tapRst)
      tap.shDr && (t_q.ir == bst_pkg::IR_BYPASS) ##1 tap.shDr
      |-> (t_q.dr[0] == $past(tdi)))
      else $error("bypass cell did not carry tdi");
   tdo_src_a: assert property (@(negedge tck) disable iff (tapRst)
      tap.shDr |=> (tdo == $past(t_q.dr[0])))
      else $error("tdo not from data chain");
   tdo_idle_a: assert property (@(negedge tck) disable iff (tapRst)
      !tap.shIr && !tap.shDr |=> !tdoOe)
      else $error("tdo driven outside shift");
   hiz_pads_a: assert property (@(posedge core_clk) disable iff (rst)
      c_q.hizS[1] |=> (padOe == 11'h000))
      else $error("pads driven under high impedance");
   drive_pads_a: assert property (@(posedge core_clk) disable iff (rst)
      c_q.drvS[1] && !c_q.hizS[1] |=> (padOe == $past(cellOe)) && (padOut == $past(cellOut)))
      else $error("pads not driven from cells");
   wr_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
      regWrEn |=> !regWrEn)
      else $error("write strobe longer than one cycle");
   if_off_a: assert property (@(posedge core_clk) disable iff (rst)
      t_q.ifOff [*3] |=> hostIfOff)
      else $error("interface switch did not reach host");

   id_shift_c: cover property (@(posedge tck) tap.shDr && (t_q.ir == bst_pkg::IR_IDCODE));
   reg_wr_c: cover property (@(posedge core_clk) regWrEn);
   hiz_c: cover property (@(posedge core_clk) c_q.hizS[1]);
endmodule

`default_nettype wire

/* testbench/bst_tester_model.sv */
// bst_tester_model: behavioural test controller driving the scan link
// assumes the design samples tms and tdi on rising tck, drives tdo on falling
`default_nettype none

module bst_tester_model (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo,
   input  wire logic tdoOe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic run     = 1'b0;
   logic lastTdo = 1'b0;
   logic oeOk;
   logic tdoLine;

   // ========================================================================
   // link clock
   // runs only inside frames and parks low, as a stopped tester would
   initial tck = 1'b0;
   always #6 if (run || tck) tck = ~tck;
   initial tms = 1'b1;
   initial tdi = 1'b1;

   // a released tdo shows the inverse of its last level, not a stale copy
   always @(posedge tck) if (tdoOe === 1'b1) lastTdo <= tdo;
   assign tdoLine = (tdoOe === 1'b1) ? tdo : ~lastTdo;

   // ========================================================================
   // one tck cycle: change on falling edge, sample on rising edge
   task automatic step(input logic m, input logic d, output logic o);
      run = 1'b1;
      @(negedge tck);
      tms = m;
      tdi = d;
      @(posedge tck);
      o = tdoLine;
   endtask

   // n cycles at a fixed tms level, then the clock stops
   task automatic hold(input logic m, input int n);
      logic o;
      repeat (n) step(m, 1'b1, o);
      run = 1'b0;
   endtask

   // idle to idle scan of n bits, lsb first; ir selects the instruction path
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic o;
      dout = '0;
      oeOk = 1'b1;
      step(1'b1, 1'b1, o);
      if (ir) step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
      step(1'b0, 1'b1, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
         oeOk &= tdoOe;
      end
      step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
      run = 1'b0;
   endtask
endmodule

`default_nettype wire

/* testbench/tb_boundary_scan_tap.sv */
// tb_boundary_scan_tap: self-checking bench for the boundary scan block
// assumes bst_top with default id parameters and the tester model
`default_nettype none

module tb_boundary_scan_tap;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] CFG   = 32'hA1B2_C3D4;
   localparam logic [10:0] FOUT  = 11'h2C6;
   localparam logic [10:0] FOE   = 11'h6B3;
   localparam logic [10:0] EXT   = 11'h5A5;
   localparam logic [23:0] PAT   = 24'h963C_A5;
   localparam logic [31:0] IDEXP = 32'h6123_40AB;
   logic core_clk = 1'b0;
   logic rst      = 1'b1;
   logic tck, tms, tdi, tdo, tdoOe, hostIfOff, regWrEn;
   logic [10:0] padIn = '0;
   logic [10:0] padOut, padOe, eOut, eOe, cap;
   logic [6:0]  regRdAddr, regWrAddr;
   logic [7:0]  regRdData;
   logic [7:0]  regWrData;
   logic [14:0] wrSeen = '0;
   logic [31:0] d;
   int wrCount, base, cycles, miscompares, comparisons;

   bst_tester_model tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe));

   bst_top dut (.core_clk(core_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdoOe(tdoOe), .cfgBytes(CFG), .funcOut(FOUT), .funcOe(FOE),
      .padIn(padIn), .padOut(padOut), .padOe(padOe), .hostIfOff(hostIfOff),
      .regRdAddr(regRdAddr), .regRdData(regRdData), .regWrAddr(regWrAddr),
      .regWrData(regWrData), .regWrEn(regWrEn));

   // ========================================================================
   // core clock, register file stand-in, pad wires and watchdog
   always #2.5 core_clk = ~core_clk;

   // register file answers combinationally, as the design samples it a cycle on
   assign regRdData = {1'b1, regRdAddr};

   // pads resolve driven value against an outside level; reads return {1,addr}
   always @(posedge core_clk) begin
      padIn     <= (padOut & padOe) | (EXT & ~padOe);
      if (regWrEn === 1'b1) begin
         wrCount <= wrCount + 1;
         wrSeen  <= {regWrData, regWrAddr};
      end
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         give_verdict();
      end
   end

   // ========================================================================
   // shared helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic set_ir(input logic [3:0] code);
      tester.scan(1'b1, 4, {28'h0, code}, d);
      check(d[3:0], bst_pkg::IR_CAPVAL);
   endtask

   task automatic give_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ========================================================================
   // scenarios
   task automatic test_ids;
      tester.scan(1'b0, 32, '0, d);
      check(d, IDEXP);
      check(tester.oeOk, 1'b1);
      #20 check(tdoOe, 1'b0);
      set_ir(bst_pkg::IR_USER);
      tester.scan(1'b0, 32, '0, d);
      check(d, 32'hD4C3_B2A1);
      $display("test ids done");
   endtask

   // unassigned codes must look exactly like bypass, pads left functional
   task automatic test_bypass;
      logic [3:0] codes [4] = '{4'h0, 4'h6, 4'hB, 4'hF};
      foreach (codes[k]) begin
         set_ir(codes[k]);
         tester.scan(1'b0, 8, 32'hB4, d);
         check(d, 32'h68);
         check({padOut, padOe}, {FOUT, FOE});
      end
      $display("test bypass done");
   endtask

   // stopped clock mid-walk, then five high tms samples force reset
   task automatic test_tap_reset;
      set_ir(bst_pkg::IR_USER);
      tester.hold(1'b1, 1);
      #200 tester.hold(1'b0, 2);
      #200 tester.hold(1'b1, 5);
      tester.hold(1'b0, 1);
      tester.scan(1'b0, 32, '0, d);
      check(d, IDEXP);
      $display("test tap reset done");
   endtask

   task automatic test_pads;
      for (int i = 0; i < 11; i++) begin
         eOut[i] = PAT[2 * i + 2];
         eOe[i]  = PAT[2 * i + 3];
         cap[i]  = eOe[i] ? eOut[i] : EXT[i];
      end
      set_ir(bst_pkg::IR_SAMPLE);
      tester.scan(1'b0, 24, {8'h0, PAT}, d);
      set_ir(bst_pkg::IR_EXTEST);
      tester.hold(1'b0, 4);
      #50 check({padOut, padOe}, {eOut, eOe});
      tester.scan(1'b0, 24, {8'h0, PAT}, d);
      for (int i = 0; i < 11; i++) eOut[i] = d[2 * i + 2];
      check(eOut, cap);
      for (int i = 0; i < 11; i++) eOut[i] = PAT[2 * i + 2];
      set_ir(bst_pkg::IR_CLAMP);
      tester.hold(1'b0, 4);
      #50 check({padOut, padOe}, {eOut, eOe});
      set_ir(bst_pkg::IR_HIGHZ);
      tester.hold(1'b0, 4);
      #50 check(padOe, 11'h000);
      $display("test pads done");
   endtask

   // read access refused until the switch bit is set, then read and write
   task automatic test_regs;
      tester.hold(1'b1, 5);
      tester.hold(1'b0, 1);
      set_ir(bst_pkg::IR_REGRD);
      tester.scan(1'b0, 8, 32'h12, d);
      tester.hold(1'b0, 6);
      tester.scan(1'b0, 8, '0, d);
      check(d, 32'h0);
      set_ir(bst_pkg::IR_IFSW);
      tester.scan(1'b0, 1, 32'h1, d);
      tester.hold(1'b0, 4);
      #50 check(hostIfOff, 1'b1);
      set_ir(bst_pkg::IR_REGRD);
      tester.scan(1'b0, 8, 32'h12, d);
      tester.hold(1'b0, 6);
      #50 check(regRdAddr, 7'h12);
      tester.scan(1'b0, 8, '0, d);
      check(d, 32'h92);
      set_ir(bst_pkg::IR_REGWR);
      tester.scan(1'b0, 15, {17'h0, 8'h3C, 7'h55}, d);
      tester.hold(1'b0, 4);
      #50 base = wrCount;
      tester.scan(1'b0, 15, '0, d);
      tester.hold(1'b0, 4);
      #50 check(32'(wrCount - base), 32'h1);
      check(wrSeen, {8'h3C, 7'h55});
      $display("test regs done");
   endtask

   // ========================================================================
   // main sequence: reset held over three tck cycles while tms resets the tap
   initial begin
      fork
         tester.hold(1'b1, 6);
         begin
            repeat (3) @(posedge tck);
            @(posedge core_clk);
            rst <= 1'b0;
         end
      join
      tester.hold(1'b0, 1);
      test_ids();
      test_bypass();
      test_tap_reset();
      test_pads();
      test_regs();
      give_verdict();
   end
endmodule

`default_nettype wire
